/* File: core/fault_map_pkg.sv */
package fault_map_pkg;
    // Register byte offsets on the 32-bit slave bus
    localparam logic [5:0] OFS_MASK_1 = 6'h00;
    localparam logic [5:0] OFS_MASK_2 = 6'h04;
    localparam logic [5:0] OFS_MASK_3 = 6'h08;
    localparam logic [5:0] OFS_MASK_4 = 6'h0c;
    localparam logic [5:0] OFS_FUNC_SEL = 6'h10;
    localparam logic [5:0] OFS_EVENT_STATUS = 6'h14;
    localparam logic [5:0] OFS_EVENT_MASK = 6'h18;
    localparam logic [5:0] OFS_FAULT_NOW = 6'h1c;
    localparam logic [5:0] OFS_TERM_STATE = 6'h20;

    // Widths and reset values
    localparam int MASK_W = 16;
    localparam int GROUP_W = 7;
    localparam int CODE_W = 8;
    localparam int SEL_W = 8;
    localparam logic [MASK_W-1:0] MASK_RESET = 16'h0000;
    localparam logic [SEL_W-1:0] SEL_RESET = 8'h00;

    // Function selector values that make a terminal a fault output
    localparam logic [SEL_W-1:0] SEL_FAULT_FIRST = 8'h23;
    localparam logic [SEL_W-1:0] SEL_FAULT_LAST = 8'h26;

    // Group bit positions
    localparam int GRP_CURRENT = 0;
    localparam int GRP_VOLTAGE = 1;
    localparam int GRP_OVERLOAD = 2;
    localparam int GRP_SYSTEM = 3;
    localparam int GRP_FEEDBACK = 4;
    localparam int GRP_EXTERNAL = 5;
    localparam int GRP_COMM = 6;

    // Fault codes whose group is known
    localparam logic [CODE_W-1:0] CODE_NONE = 8'h00;
    localparam logic [CODE_W-1:0] CODE_OVERCURRENT_ACCEL = 8'h01;
    localparam logic [CODE_W-1:0] CODE_OVERCURRENT_DECEL = 8'h02;
    localparam logic [CODE_W-1:0] CODE_OVERCURRENT_CONST = 8'h03;
    localparam logic [CODE_W-1:0] CODE_GROUND_FAULT = 8'h04;
    localparam logic [CODE_W-1:0] CODE_OVERCURRENT_STOPPED = 8'h06;
    localparam logic [CODE_W-1:0] CODE_OVERVOLTAGE_ACCEL = 8'h07;
    localparam logic [CODE_W-1:0] CODE_OVERVOLTAGE_STOPPED = 8'h0a;
    localparam logic [CODE_W-1:0] CODE_UNDERVOLTAGE_ACCEL = 8'h0b;
    localparam logic [CODE_W-1:0] CODE_UNDERVOLTAGE_CONST = 8'h0d;

    // Bus access phase
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_phase_t;
endpackage

/* File: core/fault_map_if.sv */
`timescale 1ns/1ns
// Fault code in, group membership vector out
interface fault_map_if;
    import fault_map_pkg::*;
    logic [CODE_W-1:0] code;
    logic [GROUP_W-1:0] groups;
    modport lookup (input code, output groups);
    modport user (output code, input groups);
endinterface

/* File: core/fault_group_decoder.sv */
`timescale 1ns/1ns
module fault_group_decoder
    import fault_map_pkg::*;
(
    fault_map_if.lookup map // Code to group vector
);
    // Codes outside the known table map to no group, so they light nothing
    function automatic logic [GROUP_W-1:0] group_of(input logic [CODE_W-1:0] code);
        logic [GROUP_W-1:0] g;
        g = '0;
        if (code >= CODE_OVERCURRENT_ACCEL && code <= CODE_GROUND_FAULT) begin
            g[GRP_CURRENT] = 1'b1;
        end
        if (code == CODE_OVERCURRENT_STOPPED) begin
            g[GRP_CURRENT] = 1'b1;
        end
        if (code >= CODE_OVERVOLTAGE_ACCEL && code <= CODE_OVERVOLTAGE_STOPPED) begin
            g[GRP_VOLTAGE] = 1'b1;
        end
        if (code >= CODE_UNDERVOLTAGE_ACCEL && code <= CODE_UNDERVOLTAGE_CONST) begin
            g[GRP_VOLTAGE] = 1'b1;
        end
        return g;
    endfunction

    // Code zero falls in no range and so yields an empty vector
    assign map.groups = group_of(map.code);
endmodule

/* File: core/fault_group_output_mapper.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - Each of the four group masks holds 0 to 65535, resets to zero, and bits 0 to 6 each enable one group; bits 7 to 15 enable none.
// - A mask acts only on a terminal whose function selector is 35, 36, 37 or 38.
// - A fault whose group bit is set in the selected mask turns the terminal on.
// - Group bits are current 0, voltage 1, overload 2, system 3, feedback 4, external 5, comms 6.
// - Codes 1, 2, 3, 4 and 6 are current faults.
// - Codes 7 to 10 are voltage faults.
// - Codes 11 to 13 are voltage faults too.
module fault_group_output_mapper
    import fault_map_pkg::*;
#(
    parameter int NUM_TERM = 4 // Multi-function output terminals
) (
    input wire logic clk, // 250 MHz system clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic [5:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall until answer
    input wire logic [CODE_W-1:0] fault_code, // Active fault, zero when healthy
    output logic [NUM_TERM-1:0] term_out, // Terminal drive, high is active
    output logic irq // Level interrupt
);
    logic [MASK_W-1:0] mask_reg [4];
    logic [SEL_W-1:0] func_sel_reg [NUM_TERM];
    logic [NUM_TERM-1:0] event_status_reg;
    logic [NUM_TERM-1:0] event_mask_reg;
    logic [NUM_TERM-1:0] term_reg;
    logic [NUM_TERM-1:0] term_next;
    logic [NUM_TERM-1:0] rise;
    logic [CODE_W-1:0] fault_now_reg;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;
    logic [31:0] wmask;
    bus_phase_t phase_reg;
    logic req;
    logic commit_wr;
    logic [GROUP_W-1:0] groups;

    fault_map_if map_bus ();

    // Group lookup lives in its own module so the table can grow alone
    fault_group_decoder decoder (
        .map(map_bus.lookup)
    );

    assign map_bus.code = fault_code;
    assign groups = map_bus.groups;

    // Bus handshake: every access stalls one cycle, answers on the second
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & (phase_reg == BUS_IDLE);
    assign commit_wr = avs_write & (phase_reg == BUS_ACK);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg <= BUS_IDLE;
        end else begin
            unique case (phase_reg)
                BUS_IDLE: begin
                    if (req) begin
                        phase_reg <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    phase_reg <= BUS_IDLE;
                end
            endcase
        end
    end

    // Byte enables expanded to a bit mask for partial writes
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
        end
    end

    // Group masks keep all 16 bits so software reads back what it wrote
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int m = 0; m < 4; m++) begin
                mask_reg[m] <= MASK_RESET;
            end
        end else if (commit_wr) begin
            for (int m = 0; m < 4; m++) begin
                if (avs_address == OFS_MASK_1 + 6'(m * 4)) begin
                    mask_reg[m] <= (mask_reg[m] & ~wmask[MASK_W-1:0])
                        | (avs_writedata[MASK_W-1:0] & wmask[MASK_W-1:0]);
                end
            end
        end
    end

    // Function selectors, one byte per terminal, packed in one word
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int t = 0; t < NUM_TERM; t++) begin
                func_sel_reg[t] <= SEL_RESET;
            end
        end else if (commit_wr && avs_address == OFS_FUNC_SEL) begin
            for (int t = 0; t < NUM_TERM; t++) begin
                if (avs_byteenable[t]) begin
                    func_sel_reg[t] <= avs_writedata[t*8 +: 8];
                end
            end
        end
    end

    // Terminal decision: selector picks the mask, mask gates the groups
    always_comb begin
        for (int t = 0; t < NUM_TERM; t++) begin
            term_next[t] = 1'b0;
            if (func_sel_reg[t] >= SEL_FAULT_FIRST && func_sel_reg[t] <= SEL_FAULT_LAST) begin
                // Only the seven defined group bits are compared; upper mask bits are inert
                term_next[t] = |(mask_reg[2'(func_sel_reg[t] - SEL_FAULT_FIRST)][GROUP_W-1:0]
                    & groups);
            end
        end
    end

    // Registered terminal drive keeps the pins glitch free
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            term_reg <= '0;
        end else begin
            term_reg <= term_next;
        end
    end

    assign term_out = term_reg;
    assign rise = term_next & ~term_reg;

    // Snapshot of the active code for software
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_now_reg <= CODE_NONE;
        end else begin
            fault_now_reg <= fault_code;
        end
    end

    // Sticky activation events; a new event beats a same-cycle clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            event_status_reg <= '0;
        end else begin
            if (commit_wr && avs_address == OFS_EVENT_STATUS) begin
                event_status_reg <= (event_status_reg
                    & ~(avs_writedata[NUM_TERM-1:0] & wmask[NUM_TERM-1:0])) | rise;
            end else begin
                event_status_reg <= event_status_reg | rise;
            end
        end
    end

    // Interrupt enables
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            event_mask_reg <= '0;
        end else if (commit_wr && avs_address == OFS_EVENT_MASK) begin
            event_mask_reg <= (event_mask_reg & ~wmask[NUM_TERM-1:0])
                | (avs_writedata[NUM_TERM-1:0] & wmask[NUM_TERM-1:0]);
        end
    end

    assign irq = |(event_status_reg & event_mask_reg);

    // Read mux; unmapped addresses read zero
    always_comb begin
        readdata_next = '0;
        unique case (avs_address)
            OFS_MASK_1: readdata_next[MASK_W-1:0] = mask_reg[0];
            OFS_MASK_2: readdata_next[MASK_W-1:0] = mask_reg[1];
            OFS_MASK_3: readdata_next[MASK_W-1:0] = mask_reg[2];
            OFS_MASK_4: readdata_next[MASK_W-1:0] = mask_reg[3];
            OFS_FUNC_SEL: begin
                for (int t = 0; t < NUM_TERM; t++) begin
                    readdata_next[t*8 +: 8] = func_sel_reg[t];
                end
            end
            OFS_EVENT_STATUS: readdata_next[NUM_TERM-1:0] = event_status_reg;
            OFS_EVENT_MASK: readdata_next[NUM_TERM-1:0] = event_mask_reg;
            OFS_FAULT_NOW: readdata_next[CODE_W-1:0] = fault_now_reg;
            OFS_TERM_STATE: readdata_next[NUM_TERM-1:0] = term_reg;
            default: readdata_next = '0;
        endcase
    end

    // Read data captured in the stall cycle, so it stands at the answer edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            readdata_reg <= '0;
        end else if (avs_read && phase_reg == BUS_IDLE) begin
            readdata_reg <= readdata_next;
        end
    end

    assign avs_readdata = readdata_reg;
endmodule

/* File: verification/fault_map_monitor.sv */
`timescale 1ns/1ns
module fault_map_monitor
    import fault_map_pkg::*;
#(
    parameter int NUM_TERM = 4 // Terminals
) (
    input wire logic clk, // Clock
    input wire logic arst_n, // Reset
    input wire logic [5:0] avs_address, // Address
    input wire logic avs_read, // Read
    input wire logic avs_write, // Write
    input wire logic [31:0] avs_readdata, // Read data
    input wire logic avs_waitrequest, // Stall
    input wire logic [CODE_W-1:0] fault_code, // Fault
    input wire logic [NUM_TERM-1:0] term_out, // Terminals
    input wire logic irq // Interrupt
);
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // Bus answers after exactly one stall cycle
    a_stall_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("stall longer than one cycle");
    a_new_req_stalls: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
        else $error("fresh request not stalled");
    a_mask_upper_zero: assert property (avs_read && !avs_waitrequest && avs_address < 6'h10 |-> avs_readdata[31:16] == 16'h0000)
        else $error("mask upper half not zero");
    // Terminal output follows the code seen one edge earlier
    a_no_fault_dark: assert property ($past(fault_code) == CODE_NONE |-> term_out == '0)
        else $error("terminal on without fault");
    a_unknown_dark: assert property ($past(fault_code) == 8'h05 || $past(fault_code) > 8'h0d |-> term_out == '0)
        else $error("terminal on for unmapped code");
    a_rise_known: assert property (|(term_out & ~$past(term_out)) |-> $past(fault_code) inside {[8'h01:8'h04], [8'h06:8'h0d]})
        else $error("terminal rose for code outside groups");
    // A write lands at its answer edge and reaches the pins one edge later, so look two edges back
    a_change_cause: assert property ($changed(term_out) |-> $past(fault_code) != $past(fault_code, 2) || $past(avs_write, 2))
        else $error("terminal changed without cause");
    a_irq_cause: assert property ($rose(irq) |-> (|(term_out & ~$past(term_out))) || $past(avs_write))
        else $error("interrupt rose without event");
    c_term_on: cover property (|term_out);
    c_irq_rise: cover property ($rose(irq));
    c_read_done: cover property (avs_read && !avs_waitrequest);
endmodule
bind fault_group_output_mapper fault_map_monitor #(.NUM_TERM(NUM_TERM)) fault_map_monitor_i (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fault_code(fault_code),
    .term_out(term_out), .irq(irq)
);

/* File: verification/relay_bank.sv */
`timescale 1ns/1ns
module relay_bank #(
    parameter int N = 4 // Relays
) (
    input wire logic clk, // Clock
    input wire logic [N-1:0] coil, // Terminal drive
    output logic [N-1:0] contact_reg // Contacts
);
    // Contacts pick up one clock late, like a real relay lags its coil
    always_ff @(posedge clk) begin
        contact_reg <= coil;
    end
endmodule

/* File: verification/fault_group_output_mapper_bench.sv */
`timescale 1ns/1ns
module fault_group_output_mapper_bench;
    import fault_map_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] fault_code = 8'h00;
    logic [3:0] term_out;
    logic [3:0] contact;
    logic irq;
    int n_errors = 0;
    int checks_done = 0;
    int seed = 32'h5812;
    logic [15:0] mask [4];
    logic [31:0] sel;
    logic [31:0] rd;
    logic [31:0] r;
    always #2 clk = ~clk;
    fault_group_output_mapper fault_group_output_mapper_i (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fault_code(fault_code),
        .term_out(term_out), .irq(irq));
    relay_bank relay_bank_i (.clk(clk), .coil(term_out), .contact_reg(contact));
    // Expected group vector; codes outside the known table map to nothing
    function automatic logic [6:0] groups_of(input logic [7:0] c);
        if (c inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h06}) return 7'h01;
        if (c inside {[8'h07:8'h0d]}) return 7'h02;
        return 7'h00;
    endfunction
    function automatic logic [3:0] term_of(input logic [7:0] c);
        logic [3:0] t;
        logic [7:0] s;
        t = 4'h0;
        for (int i = 0; i < 4; i++) begin
            s = sel[8*i +: 8];
            if (s >= SEL_FAULT_FIRST && s <= SEL_FAULT_LAST) t[i] = |(mask[s - SEL_FAULT_FIRST][6:0] & groups_of(c));
        end
        return t;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Held request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
        logic w;
        w = 1'b1;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        for (int n = 0; n < 20 && w !== 1'b0; n++) begin
            @(negedge clk);
            w = avs_waitrequest;
            @(posedge clk);
            if (w === 1'b0) begin
                rd = avs_readdata; // Taken at the edge where the stall is seen low
            end
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (w !== 1'b0) begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    task automatic settle_and_check(input string what, input logic [31:0] exp);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check(what, {28'h0, term_out}, exp);
    endtask
    initial begin
        for (int i = 0; i < 4; i++) mask[i] = 16'h0;
        sel = 32'h0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        // Every register and unmapped hole reads zero after reset
        bus(1'b1, 6'h3c, 32'hffffffff, 4'hf);
        for (int a = 0; a < 64; a += 4) begin
            bus(1'b0, a[5:0], 32'h0, 4'hf);
            check("reset value", rd, 32'h0);
        end
        $display("reset test done");
        // Full range and single lane on a mask
        bus(1'b1, OFS_MASK_2, 32'hffffffff, 4'hf);
        bus(1'b0, OFS_MASK_2, 32'h0, 4'hf);
        check("mask full", rd, 32'h0000ffff);
        bus(1'b1, OFS_MASK_2, 32'h0000abcd, 4'h1);
        bus(1'b0, OFS_MASK_2, 32'h0, 4'hf);
        check("mask lane", rd, 32'h0000ffcd);
        mask[1] = 16'hffcd;
        $display("mask test done");
        // Random masks, selectors 34..41 and codes 0..15; upper-bit-only masks as corner
        for (int k = 0; k < 300; k++) begin
            r = $random(seed);
            if (r[0]) begin
                mask[r[2:1]] = r[3] ? 16'hff80 : r[31:16];
                bus(1'b1, {2'b00, r[2:1], 2'b00}, {16'h0, mask[r[2:1]]}, 4'hf);
            end else begin
                sel[8*r[2:1] +: 8] = 8'h22 + {5'h0, r[6:4]};
                bus(1'b1, OFS_FUNC_SEL, sel, 4'hf);
            end
            fault_code <= {4'h0, r[11:8]};
            settle_and_check("terminals", {28'h0, term_of({4'h0, r[11:8]})});
            check("relay", {28'h0, contact}, {28'h0, term_of(fault_code)});
        end
        $display("mapping test done");
        // Masked, unmasked and cleared interrupt on a terminal rise
        sel = 32'h00000023;
        mask[0] = 16'h0001;
        bus(1'b1, OFS_MASK_1, 32'h1, 4'hf);
        bus(1'b1, OFS_FUNC_SEL, sel, 4'hf);
        bus(1'b1, OFS_EVENT_MASK, 32'h0, 4'hf);
        fault_code <= 8'h00;
        settle_and_check("dark", 32'h0);
        bus(1'b1, OFS_EVENT_STATUS, 32'hf, 4'hf);
        fault_code <= CODE_GROUND_FAULT;
        settle_and_check("lit", 32'h1);
        check("irq masked", {31'h0, irq}, 32'h0);
        bus(1'b0, OFS_TERM_STATE, 32'h0, 4'hf);
        check("terminal state", rd, 32'h1);
        bus(1'b0, OFS_FAULT_NOW, 32'h0, 4'hf);
        check("fault snapshot", rd, {24'h0, CODE_GROUND_FAULT});
        bus(1'b1, OFS_EVENT_MASK, 32'h1, 4'hf);
        // The enable lands at the answer edge, so look once it has settled
        @(negedge clk);
        check("irq on", {31'h0, irq}, 32'h1);
        bus(1'b1, OFS_EVENT_STATUS, 32'h1, 4'hf);
        bus(1'b0, OFS_EVENT_STATUS, 32'h0, 4'hf);
        check("status cleared", rd, 32'h0);
        @(negedge clk);
        check("irq off", {31'h0, irq}, 32'h0);
        $display("interrupt test done");
        tally_and_finish();
    end
endmodule
